//--- logic/scrk_device.sv
// Processor end: stop-grant control, restart and pin level keeping
`timescale 1ns/100ps
`default_nettype none
module scrk_device
    import scrk_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    scrk_link_if.device link,
    input wire logic [scrk_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_valid_i,
    input wire logic [scrk_pkg::BE_W-1:0] wr_be_n_i,
    input wire logic [scrk_pkg::UADDR_W-1:0] wr_addr_i,
    output logic wr_ready_o,
    output logic low_power_o,
    output logic halted_o
);
    scrk_dev_state_t state_q, state_d;
    logic stop_meta_q, stop_sync_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] keep_data_q, keep_data_d;
    logic [PAR_W-1:0] keep_par_q, keep_par_d;
    logic [UADDR_W-1:0] addr_q, addr_d;
    logic [BE_W-1:0] be_q, be_d;
    logic halted_q, halted_d;
    logic in_lp;
    logic hold_float;
    logic [PAR_W-1:0] par_gen;

    // Two-flop synchroniser, active-low request
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            stop_meta_q <= 1'b0;
            stop_sync_q <= 1'b0;
        end
        else
        begin
            stop_meta_q <= ~link.stop_clock_request_n;
            stop_sync_q <= stop_meta_q;
        end
    end

    assign in_lp = (state_q == SCRK_GRANT) || (state_q == SCRK_RESTART);
    assign hold_float = in_lp && link.hold_request;
    assign par_gen = {~^wr_data_i[15:8], ~^wr_data_i[7:0]};

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        halted_d = halted_q;
        keep_data_d = keep_data_q;
        keep_par_d = keep_par_q;
        addr_d = addr_q;
        be_d = be_q;
        unique case (state_q)
            SCRK_RUN:
            begin
                // One 16-bit piece per accepted word
                if (wr_valid_i)
                begin
                    keep_data_d = wr_data_i;
                    keep_par_d = par_gen;
                    addr_d = wr_addr_i;
                    be_d = wr_be_n_i;
                end
                if (stop_sync_q)
                begin
                    state_d = SCRK_STOPPING;
                end
            end
            SCRK_STOPPING:
            begin
                be_d = GRANT_BE_N;
                state_d = SCRK_GRANT;
            end
            SCRK_GRANT:
            begin
                if (!link.clk_run)
                begin
                    halted_d = 1'b1;
                end
                else if (halted_q)
                begin
                    halted_d = 1'b0;
                    cnt_d = RESTART_CNT - 4'h1;
                    state_d = SCRK_RESTART;
                end
                else if (!stop_sync_q)
                begin
                    state_d = SCRK_RUN;
                end
            end
            SCRK_RESTART:
            begin
                if (cnt_q == '0)
                begin
                    state_d = SCRK_GRANT;
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
        endcase
        // Keepers follow the pin; no tracking while bus is floated
        if (in_lp && !hold_float)
        begin
            keep_data_d = link.data_bus_pins;
        end
        if (!hold_float && state_q != SCRK_RUN)
        begin
            keep_par_d = link.data_parity_pins;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= SCRK_RUN;
            cnt_q <= '0;
            halted_q <= 1'b0;
            keep_data_q <= DATA_RST;
            keep_par_q <= PAR_RST;
            addr_q <= UADDR_RST;
            be_q <= 4'hf;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            halted_q <= halted_d;
            keep_data_q <= keep_data_d;
            keep_par_q <= keep_par_d;
            addr_q <= addr_d;
            be_q <= be_d;
        end
    end

    assign wr_ready_o = (state_q == SCRK_RUN) && !stop_sync_q;
    assign low_power_o = in_lp;
    assign halted_o = halted_q;
    assign link.grant_ind = in_lp;
    assign link.hold_acknowledge = hold_float;
    assign link.byte_lane_enables_n = be_q;
    assign link.upper_address_pins = addr_q;
    assign link.upper_address_oe = !(hold_float || link.address_hold_request);
    assign link.dev_data_o = keep_data_q;
    assign link.dev_data_oe = (in_lp || state_q == SCRK_STOPPING) && !hold_float;
    assign link.dev_par_o = keep_par_q;
    assign link.dev_par_oe = !hold_float;
endmodule // scrk_device
`default_nettype wire

//--- logic/scrk_pkg.sv
// Shared constants and types for the stop-clock restart and pin keeper
package scrk_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PAR_W = 2;
    localparam int unsigned UADDR_W = 28;
    localparam int unsigned BE_W = 4;
    localparam int unsigned RESTART_CYCLES = 8;
    localparam int unsigned SETTLE_CYCLES = 8;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] RESTART_CNT = CNT_W'(RESTART_CYCLES);
    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYCLES);
    // Halt gap limit; not used, the device flags a halt on the first grant cycle with clk_run low
    localparam logic [CNT_W-1:0] HALT_GAP_CNT = 4'h2;
    // Stop-grant special cycle indication
    localparam logic [BE_W-1:0] GRANT_BE_N = 4'hb;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [PAR_W-1:0] PAR_RST = 2'h3;
    localparam logic [UADDR_W-1:0] UADDR_RST = 28'h0000000;

    typedef enum logic [1:0]
    {
        SCRK_RUN = 2'b00,
        SCRK_STOPPING = 2'b01,
        SCRK_GRANT = 2'b10,
        SCRK_RESTART = 2'b11
    } scrk_dev_state_t;

    typedef enum logic [2:0]
    {
        SCRK_H_IDLE = 3'b000,
        SCRK_H_WAIT_GRANT = 3'b001,
        SCRK_H_HALTED = 3'b010,
        SCRK_H_SETTLE = 3'b011,
        SCRK_H_RELEASE = 3'b100
    } scrk_host_state_t;

    // Two lowest address bits from byte enables (16-bit bus)
    function automatic logic [1:0] scrk_low_addr(input logic [BE_W-1:0] be_n);
        logic a1;
        a1 = be_n[0] & be_n[1];
        return {a1, 1'b0};
    endfunction

    // Byte-lane enables {high_n, low_n}
    function automatic logic [1:0] scrk_lane_n(input logic [BE_W-1:0] be_n);
        logic hi_n;
        logic lo_n;
        hi_n = be_n[1] & be_n[3];
        lo_n = be_n[0] & be_n[2];
        return {hi_n, lo_n};
    endfunction
endpackage

//--- logic/scrk_link_if.sv
// Link between the processor end and the clock-controlling system end
`timescale 1ns/100ps
`default_nettype none
interface scrk_link_if;
    logic stop_clock_request_n;
    logic clk_run;
    logic hold_request;
    logic address_hold_request;
    logic hold_acknowledge;
    logic [scrk_pkg::BE_W-1:0] byte_lane_enables_n;
    logic [scrk_pkg::UADDR_W-1:0] upper_address_pins;
    logic upper_address_oe;
    logic grant_ind;
    logic [scrk_pkg::DATA_W-1:0] dev_data_o;
    logic dev_data_oe;
    logic [scrk_pkg::PAR_W-1:0] dev_par_o;
    logic dev_par_oe;
    logic [scrk_pkg::DATA_W-1:0] sys_data_o;
    logic sys_data_oe;
    logic [scrk_pkg::PAR_W-1:0] sys_par_o;
    logic sys_par_oe;
    logic [scrk_pkg::DATA_W-1:0] data_bus_pins;
    logic [scrk_pkg::PAR_W-1:0] data_parity_pins;

    // Resolved wire levels; pull-up when nobody drives
    assign data_bus_pins = sys_data_oe ? sys_data_o :
        (dev_data_oe ? dev_data_o : '1);
    assign data_parity_pins = sys_par_oe ? sys_par_o :
        (dev_par_oe ? dev_par_o : '1);

    modport device (
        input stop_clock_request_n, clk_run, hold_request, address_hold_request,
        input data_bus_pins, data_parity_pins,
        output hold_acknowledge, byte_lane_enables_n, upper_address_pins,
        output upper_address_oe, grant_ind, dev_data_o, dev_data_oe, dev_par_o, dev_par_oe
    );
    modport system (
        output stop_clock_request_n, clk_run, hold_request, address_hold_request,
        output sys_data_o, sys_data_oe, sys_par_o, sys_par_oe,
        input data_bus_pins, data_parity_pins, hold_acknowledge,
        input byte_lane_enables_n, upper_address_pins, upper_address_oe, grant_ind
    );
endinterface
`default_nettype wire

//--- logic/scrk_system.sv
// System end: stop request sequencing and clock rate change control
`timescale 1ns/100ps
`default_nettype none
module scrk_system
    import scrk_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    scrk_link_if.system link,
    input wire logic change_req_i,
    input wire logic halt_req_i,
    input wire logic hold_req_i,
    input wire logic address_hold_request_req_i,
    input wire logic [scrk_pkg::DATA_W-1:0] force_data_i,
    input wire logic force_valid_i,
    output logic clk_gate_o,
    output logic busy_o,
    output logic done_o,
    output logic [1:0] low_addr_o,
    output logic [1:0] lane_n_o
);
    scrk_host_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [1:0] la_q, ln_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        unique case (state_q)
            SCRK_H_IDLE:
            begin
                if (change_req_i || halt_req_i)
                begin
                    state_d = SCRK_H_WAIT_GRANT;
                end
            end
            SCRK_H_WAIT_GRANT:
            begin
                if (link.grant_ind)
                begin
                    state_d = halt_req_i ? SCRK_H_HALTED : SCRK_H_SETTLE;
                    cnt_d = SETTLE_CNT - 4'h1;
                end
            end
            SCRK_H_HALTED:
            begin
                if (!halt_req_i)
                begin
                    state_d = SCRK_H_SETTLE;
                    cnt_d = SETTLE_CNT - 4'h1;
                end
            end
            SCRK_H_SETTLE:
            begin
                // Clock must run at new rate for eight periods
                if (cnt_q == '0 && link.grant_ind)
                begin
                    state_d = SCRK_H_RELEASE;
                end
                else if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            SCRK_H_RELEASE:
            begin
                if (!link.grant_ind)
                begin
                    state_d = SCRK_H_IDLE;
                    done_d = 1'b1;
                end
            end
            default:
            begin
                state_d = SCRK_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= SCRK_H_IDLE;
            cnt_q <= '0;
            done_q <= 1'b0;
            la_q <= 2'h0;
            ln_q <= 2'h3;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            la_q <= scrk_low_addr(link.byte_lane_enables_n);
            ln_q <= scrk_lane_n(link.byte_lane_enables_n);
        end
    end

    // Clock held steady except while halted in grant
    assign link.clk_run = (state_q != SCRK_H_HALTED);
    assign clk_gate_o = (state_q != SCRK_H_HALTED);
    assign link.stop_clock_request_n = (state_q == SCRK_H_IDLE) ||
        (state_q == SCRK_H_RELEASE);
    assign link.hold_request = hold_req_i;
    assign link.address_hold_request = address_hold_request_req_i;
    assign link.sys_data_o = force_data_i;
    assign link.sys_data_oe = force_valid_i;
    assign link.sys_par_o = {~^force_data_i[15:8], ~^force_data_i[7:0]};
    assign link.sys_par_oe = force_valid_i;
    assign busy_o = (state_q != SCRK_H_IDLE);
    assign done_o = done_q;
    assign low_addr_o = la_q;
    assign lane_n_o = ln_q;
endmodule // scrk_system
`default_nettype wire

//--- verif/scrk_properties.sv
// Concurrent checks on the link between the two ends
`timescale 1ns/100ps
`default_nettype none
module scrk_properties
    import scrk_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic stop_clock_request_n,
    input wire logic clk_run,
    input wire logic hold_request,
    input wire logic address_hold_request,
    input wire logic hold_acknowledge,
    input wire logic [scrk_pkg::BE_W-1:0] byte_lane_enables_n,
    input wire logic [scrk_pkg::UADDR_W-1:0] upper_address_pins,
    input wire logic upper_address_oe,
    input wire logic grant_ind,
    input wire logic dev_data_oe,
    input wire logic dev_par_oe,
    input wire logic sys_data_oe,
    input wire logic [scrk_pkg::DATA_W-1:0] data_bus_pins
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_grant_entry;
        $fell(stop_clock_request_n) && !grant_ind |-> ##[3:5] grant_ind;
    endproperty
    a_grant_entry: assert property (p_grant_entry) else $error("late grant");
    property p_grant_code;
        $rose(grant_ind) |-> byte_lane_enables_n == GRANT_BE_N;
    endproperty
    a_grant_code: assert property (p_grant_code) else $error("grant code");
    property p_release;
        $rose(stop_clock_request_n) |-> ##[2:12] !grant_ind;
    endproperty
    a_release: assert property (p_release) else $error("no resume");
    property p_keep_drive;
        grant_ind && !hold_acknowledge && !sys_data_oe |-> dev_data_oe;
    endproperty
    a_keep_drive: assert property (p_keep_drive) else $error("data floats");
    property p_par_keep;
        !hold_acknowledge && !sys_data_oe |-> dev_par_oe;
    endproperty
    a_par_keep: assert property (p_par_keep) else $error("parity floats");
    property p_hold_float;
        hold_acknowledge |-> !dev_data_oe && !dev_par_oe && !upper_address_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("hold drive");
    property p_hold_ack;
        grant_ind && clk_run && hold_request |-> ##[0:2] hold_acknowledge;
    endproperty
    a_hold_ack: assert property (p_hold_ack) else $error("no hold ack");
    property p_address_hold_request;
        address_hold_request |-> ##[0:1] !upper_address_oe;
    endproperty
    a_address_hold_request: assert property (p_address_hold_request) else $error("address driven");
    property p_prev_state;
        grant_ind && $past(grant_ind) |-> $stable(upper_address_pins)
            && $stable(byte_lane_enables_n);
    endproperty
    a_prev_state: assert property (p_prev_state) else $error("pins moved");
    property p_adopt;
        $fell(sys_data_oe) && grant_ind && !hold_acknowledge
            |-> data_bus_pins == $past(data_bus_pins);
    endproperty
    a_adopt: assert property (p_adopt) else $error("level lost");
    c_grant: cover property ($rose(grant_ind));
    c_hold: cover property ($rose(hold_acknowledge));
    c_halt: cover property ($fell(clk_run) && grant_ind);
    c_adopt: cover property ($fell(sys_data_oe) && grant_ind);
endmodule // scrk_properties
`default_nettype wire

//--- verif/stop_clock_restart_pin_keeper_tb.sv
// Self-checking bench joining both ends of the stop-clock link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 60) begin @(negedge clock_i); k++; end \
    if (k == 60) begin fail_count++; stop_test(); end end
module stop_clock_restart_pin_keeper_tb;
    import scrk_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] wr_data = '0, force_data = '0;
    logic [27:0] wr_addr = '0;
    logic [3:0] wr_be_n = 4'hf, be;
    logic wr_valid = 0, change_req = 0, halt_req = 0, hold_req = 0, address_hold_request_req = 0;
    logic force_valid = 0, wr_ready, done;
    logic low_power, clk_gate, busy, halted;
    logic [1:0] low_addr, lane_n;
    logic [31:0] rnd = 32'h0001111f;
    logic [3:0] be_tab [6] = '{4'he, 4'hd, 4'hc, 4'h7, 4'hb, 4'h3};
    int fail_count = 0, n_checks = 0, k, i;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    function automatic logic [3:0] exp_lanes(input logic [3:0] b);
        return {b[0] & b[1], 1'b0, b[1] & b[3], b[0] & b[2]};
    endfunction
    function automatic logic [1:0] exp_par(input logic [15:0] d);
        return {~^d[15:8], ~^d[7:0]};
    endfunction
    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always #20 clock_i = ~clock_i;
    scrk_link_if link ();
    scrk_device scrk_device_i (.clock_i(clock_i), .reset_i(reset_i), .link(link.device),
        .wr_data_i(wr_data), .wr_valid_i(wr_valid), .wr_be_n_i(wr_be_n), .wr_addr_i(wr_addr),
        .wr_ready_o(wr_ready), .low_power_o(low_power), .halted_o(halted));
    scrk_system scrk_system_i (.clock_i(clock_i), .reset_i(reset_i), .link(link.system),
        .change_req_i(change_req), .halt_req_i(halt_req), .hold_req_i(hold_req),
        .address_hold_request_req_i(address_hold_request_req), .force_data_i(force_data), .force_valid_i(force_valid),
        .clk_gate_o(clk_gate), .busy_o(busy), .done_o(done), .low_addr_o(low_addr),
        .lane_n_o(lane_n));
    scrk_properties scrk_properties_i (.clock_i(clock_i), .reset_i(reset_i),
        .stop_clock_request_n(link.stop_clock_request_n), .clk_run(link.clk_run),
        .hold_request(link.hold_request), .address_hold_request(link.address_hold_request),
        .hold_acknowledge(link.hold_acknowledge), .byte_lane_enables_n(link.byte_lane_enables_n),
        .upper_address_pins(link.upper_address_pins), .upper_address_oe(link.upper_address_oe),
        .grant_ind(link.grant_ind), .dev_data_oe(link.dev_data_oe), .dev_par_oe(link.dev_par_oe),
        .sys_data_oe(link.sys_data_oe), .data_bus_pins(link.data_bus_pins));
    initial
    begin
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            rnd = nxt(rnd);
            be = be_tab[rnd[18:16] % 6];
            @(posedge clock_i);
            wr_valid <= 1'b1;
            wr_data <= rnd[15:0];
            wr_be_n <= be;
            wr_addr <= rnd[27:0];
            @(posedge clock_i);
            wr_valid <= 1'b0;
            address_hold_request_req <= 1'b1;
            repeat (2) @(negedge clock_i);
            `CHK(link.upper_address_oe, 1'b0, "address float")
            `CHK({low_addr, lane_n}, exp_lanes(be), "lanes")
            @(posedge clock_i);
            address_hold_request_req <= 1'b0;
            change_req <= 1'b1;
            halt_req <= 1'b1;
            `WAITF(halted === 1'b1)
            `CHK({low_power, clk_gate, busy}, 3'b101, "halt state")
            `CHK(link.upper_address_pins, wr_addr, "address kept")
            `CHK(link.byte_lane_enables_n, GRANT_BE_N, "grant code")
            @(posedge clock_i);
            force_valid <= 1'b1;
            force_data <= rnd[31:16] ^ wr_data;
            repeat (2) @(posedge clock_i);
            force_valid <= 1'b0;
            repeat (2) @(negedge clock_i);
            `CHK(link.data_bus_pins, force_data, "data kept")
            `CHK(link.data_parity_pins, exp_par(force_data), "parity kept")
            @(posedge clock_i);
            halt_req <= 1'b0;
            hold_req <= 1'b1;
            repeat (3) @(negedge clock_i);
            `CHK({link.hold_acknowledge, link.data_bus_pins}, {1'b1, 16'hffff}, "float")
            @(posedge clock_i);
            hold_req <= 1'b0;
            repeat (2) @(negedge clock_i);
            `CHK(link.data_bus_pins, force_data, "data restored")
            @(posedge clock_i);
            change_req <= 1'b0;
            `WAITF(done === 1'b1)
            @(negedge clock_i);
            `CHK({link.grant_ind, wr_ready}, 2'b01, "running again")
        end
        // Rate change without halting the clock
        @(posedge clock_i);
        change_req <= 1'b1;
        `WAITF(link.grant_ind === 1'b1)
        @(posedge clock_i);
        change_req <= 1'b0;
        `WAITF(link.stop_clock_request_n === 1'b1)
        `CHK(k >= int'(SETTLE_CYCLES) - 1, 1'b1, "settle too short")
        `CHK({clk_gate, halted}, 2'b10, "clock kept")
        `WAITF(done === 1'b1)
        @(negedge clock_i);
        `CHK({link.grant_ind, wr_ready, busy}, 3'b010, "resumed")
        stop_test();
    end
endmodule // stop_clock_restart_pin_keeper_tb
`default_nettype wire
